/* File: inc/ocg_pkg.sv */
// Package with register map, field layout, reset values and timing counts of the clock block.
package ocg_pkg;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam logic [3:0]  ADDR_MULT   = 4'h0;
    localparam logic [3:0]  ADDR_OSCCTL = 4'h1;
    localparam logic [3:0]  ADDR_POST   = 4'h2;
    localparam logic [3:0]  ADDR_STATUS = 4'h3;
    localparam logic [3:0]  ADDR_MASK   = 4'h4;

    // ************************************************************
    // Field layout and reset values.
    // ************************************************************
    localparam int          DIV_W        = 9;
    localparam logic [8:0]  DIV_RESET    = 9'h030;
    localparam logic [9:0]  MULT_OFFSET  = 10'h002;
    localparam int          SRC_LSB      = 0;
    localparam int          SRC_W        = 2;
    localparam int          SWITCH_BIT   = 4;
    localparam int          MONEN_BIT    = 5;
    localparam int          DOZEEN_BIT   = 6;
    localparam int          DOZE_LSB     = 8;
    localparam int          DOZE_W       = 3;
    localparam int          POST_W       = 3;
    localparam logic [2:0]  POST_RESET   = 3'h0;
    localparam logic [2:0]  DOZE_RESET   = 3'h0;
    localparam int          EVT_FAIL     = 0;
    localparam int          EVT_SWDONE   = 1;
    localparam int          EVT_W        = 2;

    // ************************************************************
    // Timing: a primary source with no edge for this long counts as failed.
    // ************************************************************
    localparam int          CLK_MHZ       = 100;
    localparam int          FAIL_NS       = 2000;
    localparam int          FAIL_CYCLES   = (FAIL_NS * CLK_MHZ) / 1000;

    // ************************************************************
    // Clock source codes.
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_RC      = 2'b00,
        SRC_RC_PLL  = 2'b01,
        SRC_PRI     = 2'b10,
        SRC_PRI_PLL = 2'b11
    } ocg_src_type;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_SWITCH = 2'b01,
        ST_FAILED = 2'b10
    } ocg_state_type;

endpackage : ocg_pkg

/* File: src/ocg_top.sv */
// Oscillator selection, PLL multiplier, postscaler, doze and clock fail monitor.
//
// Function
// - Divisor field is bits 8..0; multiplier is field plus two, 2 to 513.
// - Divisor field resets to the pattern giving multiplier fifty.
// - Divisor register reloads only on power-on reset, not other resets.
// - Divisor register bits 15..9 read zero and ignore writes.
// - CPU and peripheral clocks match except doze ratio 1:2 or slower.
// - Internal fast RC can feed the PLL input.
// - Software may switch the system clock source while running.
// - Programmable postscaler divides the system clock to save power.
// - Fail monitor detects loss of an active primary oscillator clock and acts itself.
// - Start-up source comes from nonvolatile configuration bits.
`timescale 1ns/1ps
`default_nettype none

module ocg_top
    import ocg_pkg::*;
#(
    parameter int FAIL_LIMIT = FAIL_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        porEvent,
    input  wire logic [1:0]  cfgSource,
    input  wire logic        priOscTick,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdata,
    output logic             irq,
    output logic             oscFailTrap,
    output logic      [1:0]  activeSource,
    output logic      [9:0]  pllMultiplier,
    output logic             cpuClockEn,
    output logic             peripheralClockEn
);

    // ************************************************************
    // Registers.
    // ************************************************************
    logic [DIV_W-1:0]  feedbackDivisor;
    logic [1:0]        requestSource;
    logic              switchReq;
    logic              monitorEnable;
    logic              dozeEnable;
    logic [DOZE_W-1:0] dozeRatio;
    logic [POST_W-1:0] postRatio;
    logic [EVT_W-1:0]  status;
    logic [EVT_W-1:0]  mask;
    logic [EVT_W-1:0]  events;
    logic              strapTaken;
    logic              failed;
    logic [15:0]       idleCount;
    logic [7:0]        postCount;
    logic [7:0]        dozeCount;
    logic              sysTick;
    ocg_state_type     state;

    wire logic writeMult   = regWrite && (regAddr == ADDR_MULT);
    wire logic writeCtl    = regWrite && (regAddr == ADDR_OSCCTL);
    wire logic writePost   = regWrite && (regAddr == ADDR_POST);
    wire logic writeStatus = regWrite && (regAddr == ADDR_STATUS);
    wire logic writeMask   = regWrite && (regAddr == ADDR_MASK);
    wire logic usesPri     = activeSource[1];

    // Next status and mask feed the interrupt flop, so irq never lags a mask write by a cycle.
    // Set wins: an event in the cycle of a write-one-to-clear keeps its bit.
    wire logic [EVT_W-1:0] next_status = (status & ~(writeStatus ? regWdata[EVT_W-1:0] : '0))
                                         | events;
    wire logic [EVT_W-1:0] next_mask   = writeMask ? regWdata[EVT_W-1:0] : mask;

    // ************************************************************
    // Feedback divisor: kept across ordinary resets.
    // ************************************************************
    // Only the power-on pulse restores the default, so a warm reset keeps the PLL setting.
    always_ff @(posedge mclk) begin
        if (porEvent) begin
            feedbackDivisor <= DIV_RESET;
        end else if (writeMult) begin
            feedbackDivisor <= regWdata[DIV_W-1:0];
        end
    end

    // Multiplier applied to a selected input that uses the PLL, including the internal RC path; one otherwise.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pllMultiplier <= 10'h000;
        end else if (activeSource[0]) begin
            pllMultiplier <= {1'b0, feedbackDivisor} + MULT_OFFSET;
        end else begin
            pllMultiplier <= 10'h001;
        end
    end

    // ************************************************************
    // Control registers.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            requestSource <= SRC_RC;
            monitorEnable <= 1'b0;
            dozeEnable    <= 1'b0;
            dozeRatio     <= DOZE_RESET;
            postRatio     <= POST_RESET;
            mask          <= '0;
        end else begin
            if (writeCtl) begin
                requestSource <= regWdata[SRC_LSB +: SRC_W];
                monitorEnable <= regWdata[MONEN_BIT];
                dozeEnable    <= regWdata[DOZEEN_BIT];
                dozeRatio     <= regWdata[DOZE_LSB +: DOZE_W];
            end
            if (writePost) begin
                postRatio <= regWdata[POST_W-1:0];
            end
            if (writeMask) begin
                mask <= regWdata[EVT_W-1:0];
            end
        end
    end

    // ************************************************************
    // Source switching state machine.
    // ************************************************************
    // The strap is read one cycle after release, never under the reset itself.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state        <= ST_RUN;
            activeSource <= SRC_RC;
            strapTaken   <= 1'b0;
            switchReq    <= 1'b0;
            failed       <= 1'b0;
            events       <= '0;
        end else begin
            events <= '0;
            if (!strapTaken) begin
                strapTaken   <= 1'b1;
                activeSource <= cfgSource;
            end else begin
                case (state)
                    ST_RUN: begin
                        if (writeCtl && regWdata[SWITCH_BIT]) begin
                            switchReq <= 1'b1;
                            state     <= ST_SWITCH;
                        end
                    end
                    ST_SWITCH: begin
                        // A primary target must show life before it is adopted.
                        if (!requestSource[1] || priOscTick) begin
                            activeSource       <= requestSource;
                            switchReq          <= 1'b0;
                            events[EVT_SWDONE] <= 1'b1;
                            state              <= ST_RUN;
                        end
                    end
                    ST_FAILED: begin
                        // Stay on the RC until software writes one to the failure flag after that flag already reads clear.
                        if (writeStatus && regWdata[EVT_FAIL] && !status[EVT_FAIL]) begin
                            failed <= 1'b0;
                            state  <= ST_RUN;
                        end
                    end
                    default: state <= ST_RUN;
                endcase
                if (monitorEnable && usesPri && idleCount >= 16'(FAIL_LIMIT)) begin
                    activeSource     <= SRC_RC;
                    failed           <= 1'b1;
                    switchReq        <= 1'b0;
                    events[EVT_FAIL] <= 1'b1;
                    state            <= ST_FAILED;
                end
            end
        end
    end

    // ************************************************************
    // Fail monitor: counts cycles since the last primary edge.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            idleCount <= '0;
        end else if (!usesPri || priOscTick) begin
            idleCount <= '0;
        end else if (idleCount < 16'(FAIL_LIMIT)) begin
            idleCount <= idleCount + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            oscFailTrap <= 1'b0;
        end else begin
            oscFailTrap <= failed;
        end
    end

    // ************************************************************
    // Postscaler and doze: enable pulses at divided rates.
    // ************************************************************
    // The postscaler divides by 2 to the power of postRatio.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            postCount <= '0;
            sysTick   <= 1'b0;
        end else if (postCount >= 8'((1 << postRatio) - 1)) begin
            postCount <= '0;
            sysTick   <= 1'b1;
        end else begin
            postCount <= postCount + 8'h01;
            sysTick   <= 1'b0;
        end
    end

    // The CPU drops sysTick pulses only when doze is on with a ratio of 1:2 or slower.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dozeCount         <= '0;
            cpuClockEn        <= 1'b0;
            peripheralClockEn <= 1'b0;
        end else begin
            peripheralClockEn <= sysTick;
            if (!dozeEnable || dozeRatio == 3'h0) begin
                cpuClockEn <= sysTick;
                dozeCount  <= '0;
            end else if (sysTick) begin
                if (dozeCount >= 8'((1 << dozeRatio) - 1)) begin
                    dozeCount  <= '0;
                    cpuClockEn <= 1'b1;
                end else begin
                    dozeCount  <= dozeCount + 8'h01;
                    cpuClockEn <= 1'b0;
                end
            end else begin
                cpuClockEn <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Interrupt status: set wins over write-one-to-clear.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & next_mask);
        end
    end

    // ************************************************************
    // Register read port; unmapped addresses read zero.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= '0;
        end else if (regRead) begin
            case (regAddr)
                ADDR_MULT:   regRdata <= {7'h00, feedbackDivisor};
                ADDR_OSCCTL: regRdata <= {5'h00, dozeRatio, 1'b0, dozeEnable, monitorEnable,
                                          switchReq, failed, 1'b0, activeSource};
                ADDR_POST:   regRdata <= {13'h0000, postRatio};
                ADDR_STATUS: regRdata <= {14'h0000, status};
                ADDR_MASK:   regRdata <= {14'h0000, mask};
                default:     regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    sequence s_failDetected;
        monitorEnable && usesPri && idleCount >= 16'(FAIL_LIMIT) && strapTaken;
    endsequence

    sequence s_onRc;
        activeSource == SRC_RC ##1 oscFailTrap;
    endsequence

    a_div_por_default: assert property (@(posedge mclk)
        porEvent |=> feedbackDivisor == DIV_RESET)
        else $error("Divisor not at default after power-on.");

    // No disable here on purpose: the divisor must ride through an ordinary reset.
    a_div_warm_keep: assert property (@(posedge mclk)
        !porEvent && !writeMult |=> $stable(feedbackDivisor))
        else $error("Divisor changed without power-on or write.");

    a_mult_decode: assert property (@(posedge mclk) disable iff (!nrst)
        activeSource[0] |=> pllMultiplier == {1'b0, $past(feedbackDivisor)} + MULT_OFFSET)
        else $error("Multiplier is not field plus two.");

    a_mult_bypass: assert property (@(posedge mclk) disable iff (!nrst)
        !activeSource[0] |=> pllMultiplier == 10'h001)
        else $error("Multiplier not one on a source without the PLL.");

    a_upper_zero: assert property (@(posedge mclk) disable iff (!nrst)
        regRead && regAddr == ADDR_MULT |=> regRdata[15:9] == 7'h00)
        else $error("Divisor upper bits not zero.");

    a_fail_to_rc: assert property (@(posedge mclk) disable iff (!nrst)
        s_failDetected |=> s_onRc)
        else $error("Failure did not move clock to RC with trap.");

    a_fail_status: assert property (@(posedge mclk) disable iff (!nrst)
        s_failDetected |=> ##1 status[EVT_FAIL])
        else $error("Failure flag not set.");

    a_clk_match: assert property (@(posedge mclk) disable iff (!nrst)
        !dozeEnable && $past(!dozeEnable) |-> cpuClockEn == peripheralClockEn)
        else $error("CPU and peripheral clocks differ outside doze.");

    a_switch_done: assert property (@(posedge mclk) disable iff (!nrst)
        state == ST_SWITCH && !requestSource[1]
        && !(monitorEnable && usesPri && idleCount >= 16'(FAIL_LIMIT))
        |=> activeSource == $past(requestSource) ##0 state == ST_RUN)
        else $error("Switch to internal source did not complete.");

    a_strap_load: assert property (@(posedge mclk) disable iff (!nrst)
        !strapTaken |=> activeSource == $past(cfgSource))
        else $error("Start-up source not taken from straps.");

    a_post_tick: assert property (@(posedge mclk) disable iff (!nrst)
        postRatio == 3'h0 && $past(postRatio) == 3'h0 && $past(nrst) |-> sysTick)
        else $error("Undivided postscaler missed a tick.");

    a_irq_level: assert property (@(posedge mclk) disable iff (!nrst)
        $past(nrst) |-> irq == |(status & mask))
        else $error("Interrupt output disagrees with status and mask.");

    a_rdata_idle: assert property (@(posedge mclk) disable iff (!nrst)
        !regRead |=> regRdata == 16'h0000)
        else $error("Read data did not return to zero after the read cycle.");

endmodule : ocg_top

`default_nettype wire

/* File: verification/tb_ocg_top.sv */
// Self-checking testbench for the oscillator selection and clock generation block.
`timescale 1ns/1ps
`default_nettype none

module tb_ocg_top;
    import ocg_pkg::*;

    // ************************************************************
    // Signals, clock and the block under test.
    // ************************************************************
    logic        mclk;
    logic        nrst;
    logic        porEvent;
    logic [1:0]  cfgSource;
    logic        priOscTick;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [15:0] regRdata;
    logic        irq;
    logic        oscFailTrap;
    logic [1:0]  activeSource;
    logic [9:0]  pllMultiplier;
    logic        cpuClockEn;
    logic        peripheralClockEn;
    logic        tickOn;
    int          error_cnt;
    int          tests_run;

    // A short fail limit keeps the monitor scenario brief.
    ocg_top #(.FAIL_LIMIT(8)) ocg_top_i (
        .mclk(mclk), .nrst(nrst), .porEvent(porEvent), .cfgSource(cfgSource),
        .priOscTick(priOscTick), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq),
        .oscFailTrap(oscFailTrap), .activeSource(activeSource),
        .pllMultiplier(pllMultiplier), .cpuClockEn(cpuClockEn),
        .peripheralClockEn(peripheralClockEn)
    );

    // The clock runs at 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // The primary oscillator ticks every other cycle while enabled; stopping it models a failure.
    always @(posedge mclk) begin
        priOscTick <= tickOn & ~priOscTick;
    end

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic results;
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Enable counts may be off by a pulse at the window edges, so a small slack is allowed.
    // The test is phrased so that an unknown count fails rather than slipping through.
    task automatic chkNear(input logic [15:0] got, input int exp);
        tests_run++;
        if ((got >= exp - 2 && got <= exp + 2) !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkNear

    task automatic tmo;
        error_cnt++;
        $display("Error at %0t: wait expired, got %h expected %h", $time, 1'b0, 1'b1);
        results();
    endtask : tmo

    task automatic regWr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : regWr

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic regRd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : regRd

    task automatic resetDut(input logic por, input logic [1:0] src);
        @(posedge mclk);
        nrst      <= 1'b0;
        porEvent  <= por;
        cfgSource <= src;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        porEvent <= 1'b0;
        @(posedge mclk);
        #1;
        chk({14'h0, activeSource}, {14'h0, src});
    endtask : resetDut

    task automatic waitSrc(input logic [1:0] src);
        int n;
        n = 0;
        while (activeSource !== src) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 60) tmo();
        end
    endtask : waitSrc

    task automatic waitTrap;
        int n;
        n = 0;
        while (oscFailTrap !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 60) tmo();
        end
    endtask : waitTrap

    task automatic countEn(output logic [15:0] cpuN, output logic [15:0] perN);
        cpuN = 16'h0000;
        perN = 16'h0000;
        repeat (128) begin
            @(posedge mclk);
            #1;
            cpuN = cpuN + 16'(cpuClockEn);
            perN = perN + 16'(peripheralClockEn);
        end
    endtask : countEn

    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic testReset;
        logic [15:0] d;
        regRd(ADDR_MULT, d);
        chk(d, 16'h0030);
        chk({6'h0, pllMultiplier}, 16'h0032);
        regWr(ADDR_MULT, 16'hfe55);
        regRd(ADDR_MULT, d);
        chk(d, 16'h0055);
        regRd(4'hf, d);
        chk(d, 16'h0000);
        regWr(4'hf, 16'hffff);
        regRd(ADDR_MULT, d);
        chk(d, 16'h0055);
        resetDut(1'b0, 2'b10);
        regRd(ADDR_MULT, d);
        chk(d, 16'h0055);
        resetDut(1'b1, 2'b01);
        regRd(ADDR_MULT, d);
        chk(d, 16'h0030);
    endtask : testReset

    // The internal RC with the PLL is active here, so the multiplier is the field plus two.
    task automatic testMult;
        logic [8:0]  fld [4];
        logic [9:0]  mul [4];
        logic [15:0] d;
        fld = '{9'h000, 9'h001, 9'h030, 9'h1ff};
        mul = '{10'h002, 10'h003, 10'h032, 10'h201};
        for (int i = 0; i < 4; i++) begin
            regWr(ADDR_MULT, {7'h7f, fld[i]});
            regRd(ADDR_MULT, d);
            chk(d, {7'h0, fld[i]});
            chk({6'h0, pllMultiplier}, {6'h0, mul[i]});
        end
    endtask : testMult

    task automatic testClocks;
        logic [15:0] cpuN;
        logic [15:0] perN;
        for (int n = 0; n < 4; n++) begin
            regWr(ADDR_POST, 16'(n));
            countEn(cpuN, perN);
            chkNear(perN, 128 >> n);
            chkNear(cpuN, perN);
        end
        regWr(ADDR_POST, 16'h0000);
        regWr(ADDR_OSCCTL, 16'h0040);
        countEn(cpuN, perN);
        chkNear(cpuN, perN);
        regWr(ADDR_OSCCTL, 16'h0140);
        countEn(cpuN, perN);
        chkNear(perN, 128);
        chkNear(cpuN, 64);
        regWr(ADDR_OSCCTL, 16'h0000);
    endtask : testClocks

    task automatic testSwitch;
        logic [15:0] d;
        regWr(ADDR_MASK, 16'h0002);
        regWr(ADDR_OSCCTL, 16'h0010);
        waitSrc(2'b00);
        // The multiplier follows the adopted source one cycle later.
        @(posedge mclk);
        #1;
        chk({6'h0, pllMultiplier}, 16'h0001);
        regRd(ADDR_STATUS, d);
        chk(d, 16'h0002);
        chk({15'h0, irq}, 16'h0001);
        regWr(ADDR_STATUS, 16'h0002);
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0, irq}, 16'h0000);
        regRd(ADDR_STATUS, d);
        chk(d, 16'h0000);
    endtask : testSwitch

    task automatic testFail;
        logic [15:0] d;
        @(posedge mclk);
        tickOn <= 1'b1;
        regWr(ADDR_OSCCTL, 16'h0032);
        waitSrc(2'b10);
        regWr(ADDR_STATUS, 16'h0003);
        regWr(ADDR_MASK, 16'h0001);
        regRd(ADDR_STATUS, d);
        chk(d, 16'h0000);
        chk({15'h0, oscFailTrap}, 16'h0000);
        @(posedge mclk);
        tickOn <= 1'b0;
        waitTrap();
        chk({14'h0, activeSource}, 16'h0000);
        regRd(ADDR_STATUS, d);
        chk(d & 16'h0001, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        regWr(ADDR_MASK, 16'h0000);
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0, irq}, 16'h0000);
        regWr(ADDR_STATUS, 16'h0001);
        regWr(ADDR_STATUS, 16'h0001);
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0, oscFailTrap}, 16'h0000);
    endtask : testFail

    // Main sequence; the power-on pulse is needed since the divisor has no other reset.
    initial begin
        error_cnt  = 0;
        tests_run  = 0;
        nrst       = 1'b0;
        porEvent   = 1'b1;
        cfgSource  = 2'b01;
        priOscTick = 1'b0;
        tickOn     = 1'b0;
        regAddr    = 4'h0;
        regWdata   = 16'h0000;
        regWrite   = 1'b0;
        regRead    = 1'b0;
        resetDut(1'b1, 2'b01);
        testReset();
        testMult();
        testClocks();
        testSwitch();
        testFail();
        results();
    end

endmodule : tb_ocg_top

`default_nettype wire
